// File: charger_adc_gate_config_regs.sv
// Measurement result, gate driver and reverse discharge register bank of the charge controller
//
// Contract
// - Battery voltage word: upper byte at 0x34, lower byte at 0x33.
// - Battery voltage is unsigned 2 mV steps, 0 to 7FFFh, negatives clamp to zero.
// - Thermistor word: upper byte at 0x38, lower byte at 0x37.
// - Thermistor ratio in 0.09765625 percent steps, clamped to 0..3FFh.
// - Feedback voltage word: upper byte at 0x3A, lower byte at 0x39.
// - Feedback voltage in 1 mV steps, clamped to 0..7FFh at both ends.
// - Results are read-only and read zero after power-on until a conversion.
// - Boost high-side drive bits 7:6, 00 fastest to 11 slowest, reset 00.
// - Buck high-side drive bits 5:4, same encoding, reset 00.
// - Boost low-side drive bits 3:2, same encoding, reset fastest.
// - Buck low-side drive bits 1:0, same encoding, reset fastest.
// - Boost dead time bits 3:2: 45, 75, 105, 135 ns; default 45 ns.
// - Buck dead time bits 1:0, same steps; upper four bits read zero.
// - Identification: part code bits 5:3, revision bits 2:0, bits 7:6 zero.
// - Reverse discharge limit bits 7:6: 20, 15, 10, 5 A; reset 00.
// - Bit 1 enables fast transient; resets enabled, register resets to 0x02.
// - Host programs these registers over the serial port; device accepts accesses; this bank takes them only while i_ce is high.
`timescale 1ns/10ps
module charger_adc_gate_config_regs
  import charger_regs_pkg::*;
#(
  parameter logic [2:0] PART_CODE = 3'h5,        // Arbitrary value
  parameter logic [2:0] SILICON_REVISION = 3'h2  // Arbitrary value
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_reg_defaults,
  input wire reg_req_t i_req,
  input wire conv_result_t i_conv,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output gate_cfg_t o_gate_cfg,
  output logic [1:0] o_reverse_discharge_limit,
  output logic [4:0] o_reverse_limit_amps,
  output logic o_fast_transient_enable
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] battery_voltage_result_ff;
  logic [15:0] thermistor_ratio_result_ff;
  logic [15:0] feedback_voltage_result_ff;
  logic [7:0] battery_voltage_hi_shadow_ff;
  logic [7:0] thermistor_ratio_hi_shadow_ff;
  logic [7:0] feedback_voltage_hi_shadow_ff;
  logic [7:0] gate_drive_strength_ff;
  logic [7:0] gate_dead_time_ff;
  logic [7:0] reverse_discharge_control_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  gate_cfg_t gate_cfg_ff;
  logic [4:0] reverse_limit_amps_ff;
  logic [15:0] battery_voltage_code;
  logic [15:0] thermistor_ratio_code;
  logic [15:0] feedback_voltage_code;
  logic [7:0] nxt_rdata;
  logic [7:0] part_identification;
  logic wr_en;
  logic rd_en;
  logic defaults;

  // Accesses only count while the clock enable runs
  assign wr_en = i_ce && i_req.wr;
  assign rd_en = i_ce && i_req.rd;
  assign defaults = i_srst || i_reg_defaults;
  assign part_identification = {2'h0, PART_CODE, SILICON_REVISION};

  // ****************************************************************
  // Result clamping
  // ****************************************************************
  // Battery word cannot exceed 7FFFh as signed, so only the low end clamps
  adc_code_clamp #(
    .MAX_CODE(BATTERY_VOLTAGE_MAX),
    .CLAMP_HIGH(1'b0)
  ) u_battery_voltage_clamp (
    .i_raw(i_conv.raw),
    .o_code(battery_voltage_code)
  );

  adc_code_clamp #(
    .MAX_CODE(THERMISTOR_RATIO_MAX),
    .CLAMP_HIGH(1'b1)
  ) u_thermistor_ratio_clamp (
    .i_raw(i_conv.raw),
    .o_code(thermistor_ratio_code)
  );

  adc_code_clamp #(
    .MAX_CODE(FEEDBACK_VOLTAGE_MAX),
    .CLAMP_HIGH(1'b1)
  ) u_feedback_voltage_clamp (
    .i_raw(i_conv.raw),
    .o_code(feedback_voltage_code)
  );

  // ****************************************************************
  // Result registers
  // ****************************************************************
  // Only power-on clears results; the defaults command leaves measurements alone
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      battery_voltage_result_ff <= RESULT_RESET;
      thermistor_ratio_result_ff <= RESULT_RESET;
      feedback_voltage_result_ff <= RESULT_RESET;
    end else if (i_ce && i_conv.valid) begin
      unique case (i_conv.chan)
        CH_BATTERY_VOLTAGE: battery_voltage_result_ff <= battery_voltage_code;
        CH_THERMISTOR_RATIO: thermistor_ratio_result_ff <= thermistor_ratio_code;
        CH_FEEDBACK_VOLTAGE: feedback_voltage_result_ff <= feedback_voltage_code;
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Upper byte shadows
  // ****************************************************************
  // Capture the upper byte with the lower-byte read so a conversion landing
  // between the two byte reads cannot tear the word
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      battery_voltage_hi_shadow_ff <= BYTE_ZERO;
      thermistor_ratio_hi_shadow_ff <= BYTE_ZERO;
      feedback_voltage_hi_shadow_ff <= BYTE_ZERO;
    end else if (rd_en) begin
      if (i_req.addr == ADDR_BATTERY_VOLTAGE_LO) begin
        battery_voltage_hi_shadow_ff <= battery_voltage_result_ff[15:8];
      end
      if (i_req.addr == ADDR_THERMISTOR_RATIO_LO) begin
        thermistor_ratio_hi_shadow_ff <= thermistor_ratio_result_ff[15:8];
      end
      if (i_req.addr == ADDR_FEEDBACK_VOLTAGE_LO) begin
        feedback_voltage_hi_shadow_ff <= feedback_voltage_result_ff[15:8];
      end
    end
  end

  // ****************************************************************
  // Gate driver configuration
  // ****************************************************************
  // Writes to read-only addresses fall through untouched
  always_ff @(posedge i_mclk) begin
    if (defaults) begin
      gate_drive_strength_ff <= GATE_DRIVE_STRENGTH_RESET;
      gate_dead_time_ff <= GATE_DEAD_TIME_RESET;
    end else if (wr_en) begin
      if (i_req.addr == ADDR_GATE_DRIVE_STRENGTH) begin
        gate_drive_strength_ff <= i_req.wdata;
      end
      if (i_req.addr == ADDR_GATE_DEAD_TIME) begin
        gate_dead_time_ff <= i_req.wdata & GATE_DEAD_TIME_WMASK;
      end
    end
  end

  // ****************************************************************
  // Reverse mode control
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (defaults) begin
      reverse_discharge_control_ff <= REVERSE_DISCHARGE_RESET;
    end else if (wr_en && (i_req.addr == ADDR_REVERSE_DISCHARGE_CONTROL)) begin
      reverse_discharge_control_ff <= i_req.wdata & REVERSE_DISCHARGE_WMASK;
    end
  end

  // ****************************************************************
  // Decoded outputs to the power stage
  // ****************************************************************
  // Registered one cycle behind the fields so every output leaves a flop;
  // the power stage sees a new setting one cycle after the write lands
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      gate_cfg_ff <= '0;
      reverse_limit_amps_ff <= 5'(REVERSE_LIMIT_MAX_A);
    end else if (i_ce) begin
      gate_cfg_ff.boost_high_side_drive <= gate_drive_strength_ff[BOOST_HS_DRIVE_LSB +: 2];
      gate_cfg_ff.buck_high_side_drive <= gate_drive_strength_ff[BUCK_HS_DRIVE_LSB +: 2];
      gate_cfg_ff.boost_low_side_drive <= gate_drive_strength_ff[BOOST_LS_DRIVE_LSB +: 2];
      gate_cfg_ff.buck_low_side_drive <= gate_drive_strength_ff[BUCK_LS_DRIVE_LSB +: 2];
      gate_cfg_ff.boost_dead_cycles <= dead_cycles(gate_dead_time_ff[BOOST_DEAD_LSB +: 2]);
      gate_cfg_ff.buck_dead_cycles <= dead_cycles(gate_dead_time_ff[BUCK_DEAD_LSB +: 2]);
      reverse_limit_amps_ff <= reverse_limit_amps(reverse_discharge_control_ff[REVERSE_LIMIT_LSB +: 2]);
    end
  end

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Upper result bytes come from the shadow, lower ones live; unmapped reads return zero
  always_comb begin
    nxt_rdata = BYTE_ZERO;
    unique case (i_req.addr)
      ADDR_BATTERY_VOLTAGE_LO: nxt_rdata = battery_voltage_result_ff[7:0];
      ADDR_BATTERY_VOLTAGE_HI: nxt_rdata = battery_voltage_hi_shadow_ff;
      ADDR_THERMISTOR_RATIO_LO: nxt_rdata = thermistor_ratio_result_ff[7:0];
      ADDR_THERMISTOR_RATIO_HI: nxt_rdata = thermistor_ratio_hi_shadow_ff;
      ADDR_FEEDBACK_VOLTAGE_LO: nxt_rdata = feedback_voltage_result_ff[7:0];
      ADDR_FEEDBACK_VOLTAGE_HI: nxt_rdata = feedback_voltage_hi_shadow_ff;
      ADDR_GATE_DRIVE_STRENGTH: nxt_rdata = gate_drive_strength_ff;
      ADDR_GATE_DEAD_TIME: nxt_rdata = gate_dead_time_ff;
      ADDR_PART_IDENTIFICATION: nxt_rdata = part_identification;
      ADDR_REVERSE_DISCHARGE_CONTROL: nxt_rdata = reverse_discharge_control_ff;
      default: nxt_rdata = BYTE_ZERO;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_ff <= BYTE_ZERO;
      rvalid_ff <= 1'b0;
    end else if (i_ce) begin
      rvalid_ff <= i_req.rd;
      if (i_req.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign o_rdata = rdata_ff;
  assign o_rvalid = rvalid_ff;
  assign o_gate_cfg = gate_cfg_ff;
  assign o_reverse_discharge_limit = reverse_discharge_control_ff[REVERSE_LIMIT_LSB +: 2];
  assign o_reverse_limit_amps = reverse_limit_amps_ff;
  assign o_fast_transient_enable = reverse_discharge_control_ff[FAST_TRANSIENT_BIT];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_gate_write_lands: assert property (@(posedge i_mclk) disable iff (i_srst)
    (wr_en && !i_reg_defaults && i_req.addr == ADDR_GATE_DRIVE_STRENGTH) |=>
      (gate_drive_strength_ff == $past(i_req.wdata)) ##1
      (!$past(i_ce) || o_gate_cfg.boost_high_side_drive == $past(gate_drive_strength_ff[BOOST_HS_DRIVE_LSB +: 2])))
    else $error("gate drive write did not reach the power stage");

  a_dead_upper_zero: assert property (@(posedge i_mclk) disable iff (i_srst)
    (rd_en && i_req.addr == ADDR_GATE_DEAD_TIME) |=> (o_rvalid && o_rdata[7:4] == 4'h0))
    else $error("dead time upper bits read nonzero");

  a_ident_read: assert property (@(posedge i_mclk) disable iff (i_srst)
    (rd_en && i_req.addr == ADDR_PART_IDENTIFICATION) |=>
      (o_rdata == {2'h0, PART_CODE, SILICON_REVISION}))
    else $error("identification read wrong");

  a_defaults_cmd: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_reg_defaults |=> (gate_drive_strength_ff == GATE_DRIVE_STRENGTH_RESET &&
      gate_dead_time_ff == GATE_DEAD_TIME_RESET && reverse_discharge_control_ff == REVERSE_DISCHARGE_RESET))
    else $error("defaults command did not restore configuration");

  a_fast_transient_reset: assert property (@(posedge i_mclk)
    i_srst |=> (o_fast_transient_enable && o_reverse_discharge_limit == 2'h0))
    else $error("reverse control not at reset value");

  a_result_clamps: assert property (@(posedge i_mclk) disable iff (i_srst)
    (feedback_voltage_result_ff <= FEEDBACK_VOLTAGE_MAX) && (thermistor_ratio_result_ff <= THERMISTOR_RATIO_MAX) &&
      !battery_voltage_result_ff[15])
    else $error("result above its code range");

  a_shadow_capture: assert property (@(posedge i_mclk) disable iff (i_srst)
    (rd_en && i_req.addr == ADDR_BATTERY_VOLTAGE_LO) ##1 (rd_en && i_req.addr == ADDR_BATTERY_VOLTAGE_HI) |=>
      (o_rdata == $past(battery_voltage_result_ff[15:8], 2)))
    else $error("upper byte not coherent with lower byte read");

  a_result_read_only: assert property (@(posedge i_mclk) disable iff (i_srst)
    (wr_en && !i_conv.valid && i_req.addr == ADDR_FEEDBACK_VOLTAGE_LO) |=> $stable(feedback_voltage_result_ff))
    else $error("host write changed a result");

  a_limit_amps: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && reverse_discharge_control_ff[REVERSE_LIMIT_LSB +: 2] == 2'h3) |=> (o_reverse_limit_amps == 5'h05))
    else $error("reverse limit decode wrong");

endmodule : charger_adc_gate_config_regs

// File: charger_regs_pkg.sv
// Shared constants, types and helpers for the charger measurement and gate configuration register bank
package charger_regs_pkg;

  // ****************************************************************
  // Byte addresses of the register bank
  // ****************************************************************
  localparam logic [7:0] ADDR_BATTERY_VOLTAGE_LO = 8'h33;
  localparam logic [7:0] ADDR_BATTERY_VOLTAGE_HI = 8'h34;
  localparam logic [7:0] ADDR_THERMISTOR_RATIO_LO = 8'h37;
  localparam logic [7:0] ADDR_THERMISTOR_RATIO_HI = 8'h38;
  localparam logic [7:0] ADDR_FEEDBACK_VOLTAGE_LO = 8'h39;
  localparam logic [7:0] ADDR_FEEDBACK_VOLTAGE_HI = 8'h3A;
  localparam logic [7:0] ADDR_GATE_DRIVE_STRENGTH = 8'h3B;
  localparam logic [7:0] ADDR_GATE_DEAD_TIME = 8'h3C;
  localparam logic [7:0] ADDR_PART_IDENTIFICATION = 8'h3D;
  localparam logic [7:0] ADDR_REVERSE_DISCHARGE_CONTROL = 8'h62;

  // ****************************************************************
  // Reset values, writable masks and read fill
  // ****************************************************************
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] GATE_DRIVE_STRENGTH_RESET = 8'h00;
  localparam logic [7:0] GATE_DEAD_TIME_RESET = 8'h00;
  localparam logic [7:0] GATE_DEAD_TIME_WMASK = 8'h0F;
  localparam logic [7:0] REVERSE_DISCHARGE_RESET = 8'h02;
  localparam logic [7:0] REVERSE_DISCHARGE_WMASK = 8'hC2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BOOST_HS_DRIVE_LSB = 6;
  localparam int BUCK_HS_DRIVE_LSB = 4;
  localparam int BOOST_LS_DRIVE_LSB = 2;
  localparam int BUCK_LS_DRIVE_LSB = 0;
  localparam int BOOST_DEAD_LSB = 2;
  localparam int BUCK_DEAD_LSB = 0;
  localparam int PART_CODE_LSB = 3;
  localparam int SILICON_REVISION_LSB = 0;
  localparam int REVERSE_LIMIT_LSB = 6;
  localparam int FAST_TRANSIENT_BIT = 1;

  // ****************************************************************
  // Measurement code ranges
  // ****************************************************************
  localparam logic [15:0] BATTERY_VOLTAGE_MAX = 16'h7FFF;
  localparam logic [15:0] THERMISTOR_RATIO_MAX = 16'h03FF;
  localparam logic [15:0] FEEDBACK_VOLTAGE_MAX = 16'h07FF;

  // ****************************************************************
  // Timing and limits: dead time steps, clock period and reverse limit steps
  // ****************************************************************
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int DEAD_TIME_BASE_NS = 45;
  localparam int DEAD_TIME_STEP_NS = 30;
  localparam int REVERSE_LIMIT_MAX_A = 20;
  localparam int REVERSE_LIMIT_STEP_A = 5;

  // Conversion channels that land in this bank
  typedef enum logic [1:0] {
    CH_BATTERY_VOLTAGE = 2'h0,
    CH_THERMISTOR_RATIO = 2'h1,
    CH_FEEDBACK_VOLTAGE = 2'h3
  } conv_chan_t;

  // Byte access request from the serial slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // New conversion result from the conversion engine
  typedef struct packed {
    logic valid;
    conv_chan_t chan;
    logic signed [15:0] raw;
  } conv_result_t;

  // Gate driver settings seen by the power stage
  typedef struct packed {
    logic [1:0] boost_high_side_drive;
    logic [1:0] buck_high_side_drive;
    logic [1:0] boost_low_side_drive;
    logic [1:0] buck_low_side_drive;
    logic [2:0] boost_dead_cycles;
    logic [2:0] buck_dead_cycles;
  } gate_cfg_t;

  // Dead time code to whole clock cycles, rounded up as a least time
  function automatic logic [2:0] dead_cycles(input logic [1:0] code);
    int ns;
    ns = DEAD_TIME_BASE_NS + DEAD_TIME_STEP_NS * int'(code);
    return 3'((ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  endfunction : dead_cycles

  // Discharge limit code to amperes
  function automatic logic [4:0] reverse_limit_amps(input logic [1:0] code);
    return 5'(REVERSE_LIMIT_MAX_A - REVERSE_LIMIT_STEP_A * int'(code));
  endfunction : reverse_limit_amps

endpackage : charger_regs_pkg

// File: adc_code_clamp.sv
// Clamps a signed conversion result into the unsigned code range of one result register
`timescale 1ns/10ps
module adc_code_clamp
  import charger_regs_pkg::*;
#(
  parameter logic [15:0] MAX_CODE = 16'h7FFF,
  parameter bit CLAMP_HIGH = 1'b1
) (
  input wire logic signed [15:0] i_raw,
  output logic [15:0] o_code
);

  // ****************************************************************
  // Clamp
  // ****************************************************************
  // Negative readings become zero; high clamp only where the range is narrower than the word
  always_comb begin
    if (i_raw < 0) begin
      o_code = RESULT_RESET;
    end else if (CLAMP_HIGH && (16'(i_raw) > MAX_CODE)) begin
      o_code = MAX_CODE;
    end else begin
      o_code = 16'(i_raw);
    end
  end

endmodule : adc_code_clamp

// File: reg_host_model.sv
// Host-side model issuing byte reads and writes on the register request port
`timescale 1ns/10ps
module reg_host_model
  import charger_regs_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output reg_req_t o_req
);
  // Idle fill toggles address and data so a stale request never looks held
  initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, wdata: 8'hA5};

  // One-cycle write strobe launched just after an edge
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #2 o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_mclk);
    #2 o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : write_byte

  // Read strobe; answer stands in the cycle after the taking edge
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_mclk);
    #2 o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
    @(posedge i_mclk);
    #2 o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
    d = i_rdata;
    v = i_rvalid;
  endtask : read_byte
endmodule : reg_host_model

// File: test_charger_adc_gate_config_regs.sv
// Self-checking testbench of the charger measurement and gate configuration register bank
`timescale 1ns/10ps
module test_charger_adc_gate_config_regs;
  import charger_regs_pkg::*;
  localparam logic [2:0] PART = 3'h6; // Arbitrary value
  localparam logic [2:0] REV = 3'h1;  // Arbitrary value
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic dflt = 1'b0;
  reg_req_t req;
  conv_result_t conv = '0;
  logic [7:0] rdata;
  logic rvalid;
  gate_cfg_t gcfg;
  logic [1:0] rlim;
  logic [4:0] ramps;
  logic fte;
  int n_errors = 0;
  int num_checks = 0;
  int seed = 8;
  // Reference model state: config bytes, result words and upper-byte shadows
  int gs, dt, rv;
  int res[3], shd[3];
  int lo_a[3] = '{8'h33, 8'h37, 8'h39};
  int mx[3] = '{16'h7FFF, 16'h03FF, 16'h07FF};

  // ****************************************************************
  // Clock, design and host
  // ****************************************************************
  always #12.5 mclk = ~mclk;
  charger_adc_gate_config_regs #(.PART_CODE(PART), .SILICON_REVISION(REV)) charger_adc_gate_config_regs_i (
    .i_mclk(mclk), .i_srst(srst), .i_ce(ce), .i_reg_defaults(dflt), .i_req(req), .i_conv(conv),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_gate_cfg(gcfg), .o_reverse_discharge_limit(rlim),
    .o_reverse_limit_amps(ramps), .o_fast_transient_enable(fte));
  reg_host_model reg_host_model_i (.i_mclk(mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

  // ****************************************************************
  // Model and checks
  // ****************************************************************
  // Power-on restores every reset value (reverse control to 2, the rest to zero), shadows included
  function automatic void model_reset(input bit por);
    gs = 0;
    dt = 0;
    rv = 2;
    if (por) begin
      res = '{0, 0, 0};
      shd = '{0, 0, 0};
    end
  endfunction : model_reset
  // Read side effect: a low byte read latches the upper byte
  function automatic int exp_read(input int a);
    for (int k = 0; k < 3; k++) begin
      if (a == lo_a[k]) begin
        shd[k] = res[k] >> 8;
        return res[k] & 255;
      end
      if (a == lo_a[k] + 1) return shd[k];
    end
    case (a)
      8'h3B: return gs;
      8'h3C: return dt;
      8'h3D: return {PART, REV};
      8'h62: return rv;
      default: return 0;
    endcase
  endfunction : exp_read
  // Dead time rounded up to whole 25 ns cycles
  function automatic int dcy(input int c);
    return (45 + 30 * (c & 3) + 24) / 25;
  endfunction : dcy
  task automatic chk_out(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_out
  task automatic rd_chk(input int a);
    logic [7:0] d;
    logic v;
    int e;
    e = exp_read(a);
    reg_host_model_i.read_byte(8'(a), d, v);
    chk_out($sformatf("rvalid %h", a), 16'h0001, {15'h0000, v});
    chk_out($sformatf("rdata %h", a), 16'(e), {8'h00, d});
  endtask : rd_chk
  task automatic chk_cfg;
    chk_out("gate cfg", 16'({gs[7:0], 3'(dcy(dt >> 2)), 3'(dcy(dt))}), 16'(gcfg));
    chk_out("limit code", 16'(rv >> 6), 16'(rlim));
    chk_out("limit amps", 16'(20 - 5 * (rv >> 6)), 16'(ramps));
    chk_out("fast transient", 16'((rv >> 1) & 1), 16'(fte));
  endtask : chk_cfg
  task automatic wr(input int a, input int d);
    reg_host_model_i.write_byte(8'(a), 8'(d));
    if (a == 8'h3B) gs = d & 255;
    if (a == 8'h3C) dt = d & 8'h0F;
    if (a == 8'h62) rv = d & 8'hC2;
  endtask : wr
  // One conversion pulse; unused channel code leaves the model alone
  task automatic conv_send(input int ch, input logic signed [15:0] r);
    int k;
    @(posedge mclk);
    #2 conv = '{valid: 1'b1, chan: conv_chan_t'(ch), raw: r};
    @(posedge mclk);
    #2 conv = '{valid: 1'b0, chan: conv_chan_t'(ch), raw: ~r};
    k = (ch == 3) ? 2 : ch;
    if (ch != 2) res[k] = (int'(r) < 0) ? 0 : ((int'(r) > mx[k]) ? mx[k] : int'(r));
  endtask : conv_send
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Watchdog and main sequence
  // ****************************************************************
  // Whole run needs about 480 cycles; a hang is cut well beyond that
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    int d;
    int raws[6] = '{-5, 16'h7FFF, 16'h0400, 16'h0900, 16'h03FF, 16'h8000};
    model_reset(1'b1);
    repeat (10) @(posedge mclk);
    #2 srst = 1'b0;
    // Reset values, identity and an unmapped address
    foreach (lo_a[k]) rd_chk(lo_a[k] + 1);
    foreach (lo_a[k]) rd_chk(lo_a[k]);
    for (int a = 8'h3B; a <= 8'h3D; a++) rd_chk(a);
    rd_chk(8'h62);
    rd_chk(8'h40);
    chk_cfg();
    $display("Test reset values done");
    // Every field code, then random bytes; read-only places ignore writes
    for (int i = 0; i < 8; i++) begin
      d = (i < 4) ? 8'h55 * i : $random(seed);
      wr(8'h3B, d);
      wr(8'h3C, d);
      wr(8'h62, d);
      wr(8'h33, d);
      wr(8'h3D, d);
      chk_out("rvalid after write", 16'h0000, {15'h0000, rvalid});
      repeat (2) @(posedge mclk);
      #2;
      chk_cfg();
      rd_chk(8'h3B);
      rd_chk(8'h3C);
      rd_chk(8'h62);
      rd_chk(8'h3D);
      rd_chk(8'h33);
    end
    $display("Test configuration fields done");
    // Clamping at both ends, ignored channel, stale shadow until a low read
    foreach (raws[j]) begin
      for (int ch = 0; ch < 4; ch++) begin
        conv_send(ch, 16'(j == 5 ? $random(seed) : raws[j]));
        rd_chk(lo_a[(ch == 3) ? 2 : (ch == 2 ? 1 : ch)] + 1);
        rd_chk(lo_a[(ch == 3) ? 2 : (ch == 2 ? 1 : ch)]);
        conv_send(ch, 16'h1234);
        rd_chk(lo_a[(ch == 3) ? 2 : (ch == 2 ? 1 : ch)] + 1);
      end
    end
    $display("Test conversions done");
    // Defaults command with clock enable low; requests then are ignored
    wr(8'h3B, 8'hFF);
    @(posedge mclk);
    #2 ce = 1'b0;
    reg_host_model_i.write_byte(8'h3C, 8'h0F);
    conv_send(0, 16'h0100);
    res[0] = res[0];
    res[0] = 16'h1234 == 0 ? 0 : res[0];
    @(posedge mclk);
    #2 dflt = 1'b1;
    @(posedge mclk);
    #2 dflt = 1'b0;
    ce = 1'b1;
    model_reset(1'b0);
    repeat (2) @(posedge mclk);
    #2;
    chk_cfg();
    rd_chk(8'h3B);
    rd_chk(8'h3C);
    rd_chk(8'h62);
    $display("Test defaults command done");
    // Reset in mid-run clears results and shadows
    wr(8'h62, 8'hC0);
    @(posedge mclk);
    #2 srst = 1'b1;
    repeat (2) @(posedge mclk);
    #2 srst = 1'b0;
    model_reset(1'b1);
    @(posedge mclk);
    #2;
    chk_cfg();
    rd_chk(8'h34);
    rd_chk(8'h39);
    $display("Test mid-run reset done");
    wrap_up();
  end
endmodule : test_charger_adc_gate_config_regs
